// File: src/arbiter_defines.svh
// Purpose: constants for the buffer arbiter and card address decoder
// Assumes: 10 MHz single clock, host addresses of 20 bits
// Notes: io tags are the upper address bits of each decoded range
`ifndef ARBITER_DEFINES_SVH
`define ARBITER_DEFINES_SVH

// memory window: 64 KiB, base picked by the upper host address nibble
`define WINDOW_BASE_RESET   4'h9
// io decode tags, compared against upper bits of host_addr[9:0]
`define IO_BLOCK_TAG        5'h14
`define IO_CTRL_TAG         6'h28
`define IO_PPORT_TAG        8'hA4
`define IO_TIMER_TAG        8'hA5
`define IO_CIPHER_TAG       9'h14C
// parallel port register indices within its range
`define PPORT_OUT_IDX       2'h0
`define PPORT_ADDR_IDX      2'h1
`define PPORT_STAT_IDX      2'h2
// output port field positions and reset value
`define PA_RELAY_BIT        0
`define PA_IRQ_EN_BIT       1
`define PA_CABLE_LSB        2
`define PORT_A_RESET        8'h00
// timing
`define CLOCK_PERIOD_NS     100
`define NET_HOLD_MAX_NS     1000
`define NET_HOLD_CYCLES     (`NET_HOLD_MAX_NS / `CLOCK_PERIOD_NS)
`define NET_CLK_DIV         8
`define TIMER_CLK_DIV       16

`endif

// File: src/arbiter_pkg.sv
// Purpose: types shared by the buffer arbiter
// Assumes: nothing beyond SystemVerilog enums
// Notes: no constants here, they live in the defines header
package arbiter_pkg;

	typedef enum logic [1:0] {
		HOST_IDLE,
		HOST_WAIT_BUF,
		HOST_WAIT_CTRL,
		HOST_HOLD
	} host_state_type;

	typedef enum logic [2:0] {
		DEV_NONE,
		DEV_BUFFER,
		DEV_CTRL,
		DEV_PPORT,
		DEV_TIMER,
		DEV_CIPHER
	} target_type;

endpackage : arbiter_pkg

// File: src/dual_port_buffer_arbiter.sv
// Purpose: dual port buffer arbiter and host address decoder for a ring network card
// Assumes: host pins are asynchronous; network controller runs on this clock
// Notes: clock rates for the devices are delivered as one-cycle enables
`timescale 1ns/100ps
`include "arbiter_defines.svh"
`default_nettype none

module dual_port_buffer_arbiter (
	// clock and reset
	input  wire logic        clock,
	input  wire logic        resetn,
	// host bus
	input  wire logic [19:0] host_addr,
	input  wire logic [7:0]  host_data_in,
	input  wire logic        host_mem_rd_n,
	input  wire logic        host_mem_wr_n,
	input  wire logic        host_io_rd_n,
	input  wire logic        host_io_wr_n,
	output logic      [7:0]  host_data_out,
	output logic             host_data_oe,
	output logic             host_ready,
	output logic             host_irq,
	// straps and board status
	input  wire logic [3:0]  window_base,
	input  wire logic [7:0]  station_addr,
	input  wire logic [3:0]  cable_status,
	input  wire logic        ext_irq,
	input  wire logic        power_good,
	input  wire logic        cipher_fitted,
	// network controller buffer port
	input  wire logic        net_req,
	input  wire logic        net_wr,
	input  wire logic [15:0] net_addr,
	input  wire logic [7:0]  net_wdata,
	output logic             net_grant,
	output logic      [7:0]  net_rdata,
	output logic             parity_err,
	// network controller control ports
	input  wire logic        ctrl_ack,
	output logic             ctrl_sel,
	// device selects and clocks
	output logic             cipher_sel,
	output logic      [3:0]  dev_addr,
	output logic             net_clk_en,
	output logic             timer_clk_en,
	// cable interface
	output logic             relay_energize,
	output logic      [5:0]  cable_ctrl
);

	function automatic arbiter_pkg::target_type decode(input logic [19:0] a, input logic is_mem,
		input logic [3:0] base, input logic fitted);
		decode = arbiter_pkg::DEV_NONE;
		if (is_mem) begin
			if (a[19:16] == base)
				decode = arbiter_pkg::DEV_BUFFER;
		end else if (a[9:5] == `IO_BLOCK_TAG) begin
			if (a[9:4] == `IO_CTRL_TAG)
				decode = arbiter_pkg::DEV_CTRL;
			else if (a[9:2] == `IO_PPORT_TAG)
				decode = arbiter_pkg::DEV_PPORT;
			else if (a[9:2] == `IO_TIMER_TAG)
				decode = arbiter_pkg::DEV_TIMER;
			else if (a[9:1] == `IO_CIPHER_TAG && fitted)
				decode = arbiter_pkg::DEV_CIPHER;
		end
	endfunction : decode
	// input synchronisers: stage one is read only by stage two
	logic [49:0] sync1_q;
	logic [49:0] sync2_q;
	logic [49:0] pins;
	assign pins = {host_addr, host_data_in, ~host_mem_rd_n, ~host_mem_wr_n, ~host_io_rd_n,
		~host_io_wr_n, window_base, station_addr, cable_status, ext_irq, power_good};
	logic [19:0] s_addr;
	logic [7:0]  s_wdata;
	logic        s_mem_rd;
	logic        s_mem_wr;
	logic        s_io_rd;
	logic        s_io_wr;
	logic [3:0]  s_base;
	logic [7:0]  s_station;
	logic [3:0]  s_cable;
	logic        s_ext_irq;
	logic        s_power;
	assign {s_addr, s_wdata, s_mem_rd, s_mem_wr, s_io_rd, s_io_wr, s_base, s_station,
		s_cable, s_ext_irq, s_power} = sync2_q;
	logic [8:0]  mem [0:65535];
	arbiter_pkg::host_state_type state_q, state_d;
	arbiter_pkg::target_type     tgt_q, tgt_d;
	logic [3:0]  hold_q, hold_d;
	logic [3:0]  div_q, div_d;
	logic [7:0]  port_a_q, port_a_d;
	logic [31:0] count_q, count_d;
	logic        expired_q, expired_d;
	logic [7:0]  hdata_q, hdata_d;
	logic        hoe_q, hoe_d;
	logic        ready_q, ready_d;
	logic        irq_q, irq_d;
	logic        grant_q, grant_d;
	logic [7:0]  nrdata_q, nrdata_d;
	logic        perr_q, perr_d;
	logic        csel_q, csel_d;
	logic        xsel_q, xsel_d;
	logic [3:0]  daddr_q, daddr_d;
	logic        nclk_q, nclk_d;
	logic        tclk_q, tclk_d;
	logic        relay_q, relay_d;
	logic        mem_we;
	logic [15:0] mem_addr;
	logic [8:0]  mem_wdata;
	logic [8:0]  mem_rword;
	logic        host_pend;
	logic        host_first;
	logic        grant_net;
	logic        grant_host;
	logic        strobe;
	logic        is_read;
	logic [7:0]  port_c;
	assign mem_rword = mem[mem_addr];
	assign strobe = s_mem_rd | s_mem_wr | s_io_rd | s_io_wr;
	assign is_read = s_mem_rd | s_io_rd;
	assign port_c = {s_cable, expired_q, s_ext_irq, 2'h0};
	always_comb begin
		state_d = state_q;
		tgt_d = tgt_q;
		hold_d = hold_q;
		port_a_d = port_a_q;
		count_d = count_q;
		expired_d = expired_q;
		hdata_d = hdata_q;
		hoe_d = 1'b0;
		ready_d = 1'b1;
		grant_d = 1'b0;
		nrdata_d = nrdata_q;
		perr_d = 1'b0;
		csel_d = 1'b0;
		xsel_d = 1'b0;
		daddr_d = daddr_q;
		mem_we = 1'b0;
		mem_addr = net_addr;
		mem_wdata = {^net_wdata, net_wdata};
		div_d = div_q + 4'h1;
		nclk_d = (div_q[2:0] == 3'(`NET_CLK_DIV - 1));
		tclk_d = (div_q == 4'(`TIMER_CLK_DIV - 1));
		// arbitration: network first unless the host has waited its limit
		host_pend = (state_q == arbiter_pkg::HOST_WAIT_BUF);
		host_first = host_pend && (hold_q >= 4'(`NET_HOLD_CYCLES));
		grant_net = net_req && !host_first;
		grant_host = host_pend && !grant_net;
		if (!host_pend || grant_host)
			hold_d = 4'h0;
		else if (grant_net)
			hold_d = hold_q + 4'h1;
		if (grant_net) begin
			mem_we = net_wr;
			grant_d = 1'b1;
			if (!net_wr) begin
				nrdata_d = mem_rword[7:0];
				perr_d = mem_rword[8] != ^mem_rword[7:0];
			end
		end else if (grant_host) begin
			mem_addr = s_addr[15:0];
			mem_wdata = {^s_wdata, s_wdata};
			mem_we = s_mem_wr;
			if (s_mem_rd) begin
				hdata_d = mem_rword[7:0];
				perr_d = mem_rword[8] != ^mem_rword[7:0];
			end
		end
		// timer: a single 32-bit down counter that stops at zero
		if (tclk_q && count_q != 32'h0000_0000) begin
			count_d = count_q - 32'h0000_0001;
			if (count_q == 32'h0000_0001)
				expired_d = 1'b1;
		end
		case (state_q)
			arbiter_pkg::HOST_IDLE: begin
				if (strobe) begin
					tgt_d = decode(s_addr, s_mem_rd | s_mem_wr, s_base, cipher_fitted);
					daddr_d = s_addr[3:0];
					case (tgt_d)
						arbiter_pkg::DEV_BUFFER: begin
							state_d = arbiter_pkg::HOST_WAIT_BUF;
							ready_d = 1'b0;
						end
						arbiter_pkg::DEV_CTRL: begin
							state_d = arbiter_pkg::HOST_WAIT_CTRL;
							ready_d = 1'b0;
							csel_d = 1'b1;
						end
						arbiter_pkg::DEV_PPORT: begin
							state_d = arbiter_pkg::HOST_HOLD;
							case (s_addr[1:0])
								`PPORT_OUT_IDX: hdata_d = port_a_q;
								`PPORT_ADDR_IDX: hdata_d = s_station;
								`PPORT_STAT_IDX: hdata_d = port_c;
								default: hdata_d = 8'h00;
							endcase
							if (s_io_wr && s_addr[1:0] == `PPORT_OUT_IDX)
								port_a_d = s_wdata;
						end
						arbiter_pkg::DEV_TIMER: begin
							state_d = arbiter_pkg::HOST_HOLD;
							hdata_d = 8'(count_q >> {s_addr[1:0], 3'h0});
							if (s_io_wr) begin
								count_d[{s_addr[1:0], 3'h0} +: 8] = s_wdata;
								// an expiring tick in the same cycle wins over the clear
								expired_d = tclk_q && count_q == 32'h0000_0001;
							end
						end
						arbiter_pkg::DEV_CIPHER: begin
							state_d = arbiter_pkg::HOST_HOLD;
							xsel_d = 1'b1;
						end
						default: begin
							state_d = arbiter_pkg::HOST_IDLE;
						end
					endcase
				end
			end
			arbiter_pkg::HOST_WAIT_BUF: begin
				ready_d = grant_host;
				if (grant_host)
					state_d = arbiter_pkg::HOST_HOLD;
			end
			arbiter_pkg::HOST_WAIT_CTRL: begin
				csel_d = 1'b1;
				ready_d = ctrl_ack;
				if (ctrl_ack)
					state_d = arbiter_pkg::HOST_HOLD;
			end
			arbiter_pkg::HOST_HOLD: begin
				xsel_d = (tgt_q == arbiter_pkg::DEV_CIPHER) && strobe;
				hoe_d = is_read && strobe && (tgt_q == arbiter_pkg::DEV_BUFFER ||
					tgt_q == arbiter_pkg::DEV_PPORT || tgt_q == arbiter_pkg::DEV_TIMER);
				if (!strobe)
					state_d = arbiter_pkg::HOST_IDLE;
			end
			default: begin
				state_d = arbiter_pkg::HOST_IDLE;
			end
		endcase
		irq_d = port_a_q[`PA_IRQ_EN_BIT] && (s_ext_irq || expired_q);
		// relays drop on power loss or software release
		relay_d = port_a_q[`PA_RELAY_BIT] && s_power;
	end
	always_ff @(posedge clock) begin
		if (mem_we)
			mem[mem_addr] <= mem_wdata;
	end
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			sync1_q <= '0;
			sync2_q <= '0;
			state_q <= arbiter_pkg::HOST_IDLE;
			tgt_q <= arbiter_pkg::DEV_NONE;
			hold_q <= 4'h0;
			div_q <= 4'h0;
			port_a_q <= `PORT_A_RESET;
			count_q <= 32'h0000_0000;
			expired_q <= 1'b0;
			hdata_q <= 8'h00;
			hoe_q <= 1'b0;
			ready_q <= 1'b1;
			irq_q <= 1'b0;
			grant_q <= 1'b0;
			nrdata_q <= 8'h00;
			perr_q <= 1'b0;
			csel_q <= 1'b0;
			xsel_q <= 1'b0;
			daddr_q <= 4'h0;
			nclk_q <= 1'b0;
			tclk_q <= 1'b0;
			relay_q <= 1'b0;
		end else begin
			sync1_q <= pins;
			sync2_q <= sync1_q;
			state_q <= state_d;
			tgt_q <= tgt_d;
			hold_q <= hold_d;
			div_q <= div_d;
			port_a_q <= port_a_d;
			count_q <= count_d;
			expired_q <= expired_d;
			hdata_q <= hdata_d;
			hoe_q <= hoe_d;
			ready_q <= ready_d;
			irq_q <= irq_d;
			grant_q <= grant_d;
			nrdata_q <= nrdata_d;
			perr_q <= perr_d;
			csel_q <= csel_d;
			xsel_q <= xsel_d;
			daddr_q <= daddr_d;
			nclk_q <= nclk_d;
			tclk_q <= tclk_d;
			relay_q <= relay_d;
		end
	end
	assign host_data_out = hdata_q;
	assign host_data_oe = hoe_q;
	assign host_ready = ready_q;
	assign host_irq = irq_q;
	assign net_grant = grant_q;
	assign net_rdata = nrdata_q;
	assign parity_err = perr_q;
	assign ctrl_sel = csel_q;
	assign cipher_sel = xsel_q;
	assign dev_addr = daddr_q;
	assign net_clk_en = nclk_q;
	assign timer_clk_en = tclk_q;
	assign relay_energize = relay_q;
	assign cable_ctrl = port_a_q[`PA_CABLE_LSB +: 6];

endmodule : dual_port_buffer_arbiter

`default_nettype wire

// File: test/arbiter_sva.sv
// Purpose: pin-level checks on the buffer arbiter
// Assumes: host strobes reach the logic two edges late
// Notes: bound at the foot of this file
`timescale 1ns/100ps
`default_nettype none
module arbiter_sva (
	// clock and reset
	input wire logic        clock,
	input wire logic        resetn,
	// host side
	input wire logic [19:0] host_addr,
	input wire logic        host_mem_rd_n,
	input wire logic        host_mem_wr_n,
	input wire logic        host_io_rd_n,
	input wire logic        host_io_wr_n,
	input wire logic        host_data_oe,
	input wire logic        host_ready,
	input wire logic [3:0]  window_base,
	// card side
	input wire logic        net_req,
	input wire logic        net_grant,
	input wire logic        ctrl_sel,
	input wire logic        cipher_sel,
	input wire logic        cipher_fitted,
	input wire logic        net_clk_en,
	input wire logic        timer_clk_en,
	input wire logic        power_good,
	input wire logic        relay_energize
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);
	AST_GRANT_CAUSE: assert property (net_grant |-> $past(net_req))
		else $error("grant without request");
	AST_WAIT_BOUND: assert property ($fell(host_ready) && !host_mem_rd_n |->
		##[1:16] host_ready)
		else $error("host held off too long");
	AST_WAIT_SCOPE: assert property ($fell(host_ready) |-> $past(
		(!host_mem_rd_n || !host_mem_wr_n) && host_addr[19:16] == window_base
		|| (!host_io_rd_n || !host_io_wr_n) && host_addr[9:4] == 6'h28))
		else $error("wait state on a foreign cycle");
	AST_OE_SCOPE: assert property ($rose(host_data_oe) |-> $past(
		!host_mem_rd_n && host_addr[19:16] == window_base
		|| !host_io_rd_n && host_addr[9:3] == 7'h52, 2))
		else $error("data driven on a foreign cycle");
	AST_CTRL_ADDR: assert property ($rose(ctrl_sel) |-> host_addr[9:4] == 6'h28)
		else $error("control select off range");
	AST_CIPHER: assert property ($rose(cipher_sel) |->
		cipher_fitted && host_addr[9:1] == 9'h14C)
		else $error("cipher select wrong");
	AST_NET_CLK: assert property (net_clk_en |=> !net_clk_en [*7] ##1 net_clk_en)
		else $error("network clock rate wrong");
	AST_TIMER_CLK: assert property (timer_clk_en |=> !timer_clk_en [*8] ##1
		!timer_clk_en [*7] ##1 timer_clk_en)
		else $error("timer clock rate wrong");
	AST_RELAY: assert property (!power_good [*4] |-> !relay_energize)
		else $error("relay held without power");
endmodule : arbiter_sva
bind dual_port_buffer_arbiter arbiter_sva chk (.*);
`default_nettype wire

// File: test/host_bus_model.sv
// Purpose: host bus master driving the card
// Assumes: strobes held until ready is seen high
// Notes: released data lines show the inverse of the last value
`timescale 1ns/100ps
`default_nettype none
module host_bus_model (
	// clock and answers
	input wire logic        clock,
	input wire logic        host_ready,
	input wire logic        host_data_oe,
	input wire logic [7:0]  host_data_out,
	// requests
	output logic     [19:0] host_addr,
	output logic     [7:0]  host_data_in,
	output logic            host_mem_rd_n,
	output logic            host_mem_wr_n,
	output logic            host_io_rd_n,
	output logic            host_io_wr_n
);
	initial begin
		host_addr = 20'h0_0000;
		host_data_in = 8'h00;
		{host_mem_rd_n, host_mem_wr_n, host_io_rd_n, host_io_wr_n} = 4'hF;
	end
	// kind 0 mem read, 1 mem write, 2 io read, 3 io write
	task automatic cycle(input logic [1:0] k, input logic [19:0] a, input logic [7:0] wd,
		output logic [7:0] rd, output logic oe, output int waits);
		int n;
		n = 0;
		waits = 0;
		@(posedge clock);
		#2;
		host_addr = a;
		host_data_in = wd;
		{host_mem_rd_n, host_mem_wr_n, host_io_rd_n, host_io_wr_n} = ~(4'h8 >> k);
		repeat (6) begin
			@(negedge clock);
			waits += !host_ready;
		end
		// hold the cycle through wait states
		while (host_ready !== 1'b1 && n < 300) begin
			@(negedge clock);
			waits++;
			n++;
		end
		repeat (2) @(posedge clock);
		#1;
		rd = host_data_out;
		oe = host_data_oe;
		#1;
		{host_mem_rd_n, host_mem_wr_n, host_io_rd_n, host_io_wr_n} = 4'hF;
		host_data_in = ~wd;
		repeat (4) @(posedge clock);
	endtask : cycle
endmodule : host_bus_model
`default_nettype wire

// File: test/dual_port_buffer_arbiter_tb.sv
// Purpose: self-checking bench for the buffer arbiter
// Assumes: host cycles come from host_bus_model
// Notes: reset check first, then table rows, then hand tests
`timescale 1ns/100ps
`default_nettype none
module dual_port_buffer_arbiter_tb;
	typedef struct {logic [1:0] k; logic [19:0] a; logic [7:0] wd; logic oe;
		logic [7:0] d; logic [7:0] m; logic w;} row_type;
	logic clock = 0, resetn = 0, ext_irq = 1, power_good = 1, cipher_fitted = 0;
	logic net_req = 0, net_wr = 0, ctrl_ack = 0;
	logic [3:0] window_base = 4'h9, cable_status = 4'hA;
	logic [7:0] station_addr = 8'hC3, net_wdata = 8'h00;
	logic [15:0] net_addr = 16'h0010;
	logic [19:0] host_addr;
	logic [7:0] host_data_in, host_data_out, net_rdata, rd;
	logic host_mem_rd_n, host_mem_wr_n, host_io_rd_n, host_io_wr_n, host_data_oe, host_ready;
	logic host_irq, net_grant, parity_err, ctrl_sel, cipher_sel, net_clk_en, timer_clk_en;
	logic relay_energize, oe, csel = 0, perr = 0;
	logic [3:0] dev_addr;
	logic [5:0] cable_ctrl;
	int num_errors = 0, checked = 0, cycles = 0, grants = 0, waits;
	row_type rows [15] = '{
		'{1, 20'h9_0010, 8'h5A, 0, 0, 0, 1}, '{0, 20'h9_0010, 0, 1, 8'h5A, 8'hFF, 1},
		'{1, 20'h9_FFFF, 8'hA5, 0, 0, 0, 1}, '{0, 20'h9_FFFF, 0, 1, 8'hA5, 8'hFF, 1},
		'{0, 20'h8_0010, 0, 0, 0, 0, 0}, '{2, 20'h0_0291, 0, 1, 8'hC3, 8'hFF, 0},
		'{2, 20'h0_0292, 0, 1, 8'hA4, 8'hF7, 0}, '{2, 20'h0_0293, 0, 1, 8'h00, 8'hFF, 0},
		'{3, 20'h0_0294, 8'hFF, 0, 0, 0, 0}, '{3, 20'h0_0297, 8'h80, 0, 0, 0, 0},
		'{2, 20'h0_0297, 0, 1, 8'h80, 8'hFF, 0}, '{2, 20'h0_02A0, 0, 0, 0, 0, 0},
		'{2, 20'h0_027F, 0, 0, 0, 0, 0}, '{2, 20'h0_0280, 0, 0, 0, 0, 1},
		'{2, 20'h0_0298, 0, 0, 0, 0, 0}};
	dual_port_buffer_arbiter dut (.*);
	host_bus_model host (.*);
	always #50 clock = ~clock;
	always @(posedge clock) begin
		ctrl_ack <= #2 ctrl_sel && !ctrl_ack;
		grants <= grants + net_grant;
		csel <= csel | cipher_sel;
		perr <= perr | parity_err;
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			num_errors++;
			give_verdict();
		end
	end
	task automatic note(input logic bad, input string msg);
		checked++;
		if (bad) begin
			num_errors++;
			$display("ERROR %0t %s", $time, msg);
		end
	endtask : note
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : give_verdict
	initial begin
		repeat (3) @(posedge clock);
		#2 resetn = 1;
		note(host_ready !== 1'b1 || host_data_oe !== 1'b0 || net_grant !== 1'b0, "reset");
		$display("reset test done");
		foreach (rows[i]) begin
			host.cycle(rows[i].k, rows[i].a, rows[i].wd, rd, oe, waits);
			note(oe !== rows[i].oe, "row drive");
			note(((rd ^ rows[i].d) & rows[i].m) !== 8'h00, "row data");
			note((waits > 0) !== rows[i].w, "row wait");
		end
		note(csel !== 1'b0, "cipher unfitted");
		$display("table test done");
		#2 cipher_fitted = 1;
		host.cycle(2, 20'h0_0298, 0, rd, oe, waits);
		note(csel !== 1'b1 || dev_addr !== 4'h8, "cipher fitted");
		host.cycle(3, 20'h0_0290, 8'hFF, rd, oe, waits);
		note(relay_energize !== 1'b1 || cable_ctrl !== 6'h3F, "port out");
		note(host_irq !== 1'b1, "irq on");
		#2 ext_irq = 0;
		repeat (4) @(posedge clock);
		note(host_irq !== 1'b0, "irq off");
		#2 power_good = 0;
		repeat (5) @(posedge clock);
		note(relay_energize !== 1'b0, "relay drop");
		$display("port test done");
		#2 net_req = 1;
		host.cycle(0, 20'h9_0010, 0, rd, oe, waits);
		note(waits < 2 || waits > 14, "contended wait");
		note(rd !== 8'h5A || net_rdata !== 8'h5A || grants == 0, "contended data");
		#2 net_req = 0;
		window_base = 4'hD;
		repeat (4) @(posedge clock);
		host.cycle(1, 20'hD_0010, 8'h33, rd, oe, waits);
		host.cycle(0, 20'hD_0010, 0, rd, oe, waits);
		note(rd !== 8'h33 || oe !== 1'b1, "moved window");
		host.cycle(0, 20'h9_0010, 0, rd, oe, waits);
		note(oe !== 1'b0 || perr !== 1'b0, "old window");
		#2 net_req = 1;
		net_wr = 1;
		net_addr = 16'h0020;
		net_wdata = 8'h77;
		@(posedge clock);
		#2 net_req = 0;
		net_wr = 0;
		host.cycle(0, 20'hD_0020, 0, rd, oe, waits);
		note(rd !== 8'h77 || oe !== 1'b1, "network write");
		$display("buffer test done");
		give_verdict();
	end
endmodule : dual_port_buffer_arbiter_tb
`default_nettype wire
